// File: logic/pdt_pkg.sv
// Constants and register map of the prescaled down timer
// Behaviour
// - The prescaler advances on a strobe made from the internal clock divided by twelve.
// - A prescaler at zero reloads with 7Fh and keeps counting down.
// - Software can read the live 7-bit prescaler value in its own register.
// - The counter decrements once per tick from the selected prescaler tap.
// - A counter at zero reloads with 0FFh on the next tick.
// - Software can read the live count and overwrite it at any time outside stop mode.
// - The tap select field picks one of eight taps, dividing by two to its value.
// - With the run bit clear the counter holds and the prescaler is forced to 7Fh.
// - Reset sets the counter to 0FFh and the prescaler to 7Fh.
// - With the run bit set software may write any value up to 7Fh to the prescaler.
// - A decrement to zero sets the zero flag and, if enabled, raises an interrupt.
// - Writing 00h to the counter or a one to status bit 7 also sets the zero flag.
// - A counter write in the cycle of a decrement to zero wins; the decrement sets no flag.
// - In wait mode the timer runs on and a zero interrupt requests a wake-up.
// - In stop mode all timer state is held and the zero event gives no wake-up.
`default_nettype none
package pdt_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_COUNTER        = 2'h1;
   localparam logic [1:0] ADDR_PRESCALER      = 2'h2;
   localparam logic [1:0] ADDR_IRQ_MASK       = 2'h3;
   // ----------------------------------------
   // Status/control fields
   // ----------------------------------------
   localparam int unsigned BIT_ZERO_FLAG = 7;
   localparam int unsigned BIT_IRQ_EN    = 6;
   localparam int unsigned BIT_RUN       = 3;
   localparam int unsigned TAP_LSB       = 0;
   localparam int unsigned TAP_W         = 3;
   // ----------------------------------------
   // Reset and reload values, timing
   // ----------------------------------------
   localparam logic [7:0] COUNTER_RELOAD   = 8'hFF;
   localparam logic [6:0] PRESCALER_RELOAD = 7'h7F;
   localparam logic [7:0] CTRL_RESET       = 8'h00;
   localparam logic [7:0] ZERO_BYTE        = 8'h00;
   localparam int unsigned FINT_DIVIDE     = 12;
   localparam logic [3:0] DIV_LAST         = 4'(FINT_DIVIDE - 1);
endpackage
`default_nettype wire

// File: logic/pdt_timer.sv
// Prescaled 8-bit down timer with register port and interrupt
`default_nettype none
module pdt_timer
   import pdt_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       clk_en_i,
   input  wire logic       stop_mode_i,
   input  wire logic       wait_mode_i,
   input  wire logic [1:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   output logic            irq_o,
   output logic            wake_o
);
   // ----------------------------------------
   // Global advance condition
   // ----------------------------------------
   // Stop freezes all timer state, register writes included; reads still answer
   logic       adv;
   logic [3:0] div_q;
   logic [6:0] pre_q;
   logic [7:0] cnt_q;
   logic [7:0] ctrl_q;
   logic [7:0] mask_q;
   logic       div_tick;
   logic       pre_tick;
   logic       cnt_tick;
   logic       run;
   logic [2:0] tap;
   logic       wr_ctrl;
   logic       wr_cnt;
   logic       wr_pre;
   logic       wr_mask;
   logic       zero_evt;
   logic       zero_set;
   logic [7:0] pre_prev;
   logic [7:0] pre_fall;

   assign adv      = clk_en_i && !stop_mode_i;
   assign run      = ctrl_q[BIT_RUN];
   assign tap      = ctrl_q[TAP_LSB +: TAP_W];
   assign wr_ctrl  = adv && wr_i && addr_i == ADDR_STATUS_CONTROL;
   assign wr_cnt   = adv && wr_i && addr_i == ADDR_COUNTER;
   assign wr_pre   = adv && wr_i && addr_i == ADDR_PRESCALER;
   assign wr_mask  = adv && wr_i && addr_i == ADDR_IRQ_MASK;

   // ----------------------------------------
   // Divide by twelve strobe
   // ----------------------------------------
   assign div_tick = adv && run && div_q == DIV_LAST;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_q <= 4'h0;
      end else if (adv) begin
         if (!run || div_q == DIV_LAST) begin
            div_q <= 4'h0;
         end else begin
            div_q <= div_q + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // Prescaler and tap select
   // ----------------------------------------
   // Tap n ticks every 2^n prescaler steps, at each borrow out of the low n bits
   assign pre_tick = div_tick;
   assign pre_prev = {1'b0, pre_q};

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_tap
         if (g == 0) begin : g_direct
            assign pre_fall[g] = pre_tick;
         end else begin : g_bit
            // Borrow out of the low g bits means 2^g steps elapsed
            assign pre_fall[g] = pre_tick && pre_prev[g-1:0] == '0;
         end
      end
   endgenerate

   assign cnt_tick = pre_fall[tap];

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pre_q <= PRESCALER_RELOAD;
      end else if (adv) begin
         if (!run) begin
            pre_q <= PRESCALER_RELOAD;
         end else if (wr_pre) begin
            pre_q <= wdata_i[6:0];
         end else if (pre_tick) begin
            if (pre_q == 7'h00) begin
               pre_q <= PRESCALER_RELOAD;
            end else begin
               pre_q <= pre_q - 7'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q <= COUNTER_RELOAD;
      end else if (adv) begin
         if (wr_cnt) begin
            cnt_q <= wdata_i;
         end else if (run && cnt_tick) begin
            if (cnt_q == ZERO_BYTE) begin
               cnt_q <= COUNTER_RELOAD;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // Zero flag and control
   // ----------------------------------------
   // Write beats a same-cycle decrement in both the flag and the count
   assign zero_evt = run && cnt_tick && !wr_cnt
                     && cnt_q == 8'h01;
   assign zero_set = zero_evt
                     || (wr_cnt && wdata_i == ZERO_BYTE)
                     || (wr_ctrl && wdata_i[BIT_ZERO_FLAG]);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (adv) begin
         if (wr_ctrl) begin
            ctrl_q <= wdata_i;
         end
         // Set beats a clear written in the same cycle
         if (zero_set) begin
            ctrl_q[BIT_ZERO_FLAG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mask_q <= CTRL_RESET;
      end else if (wr_mask) begin
         mask_q <= wdata_i;
      end
   end

   // ----------------------------------------
   // Interrupt and wake outputs
   // ----------------------------------------
   // Mask register shares the status layout; only the zero bit matters
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else if (clk_en_i) begin
         irq_o <= ctrl_q[BIT_ZERO_FLAG] && ctrl_q[BIT_IRQ_EN]
                  && mask_q[BIT_ZERO_FLAG];
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wake_o <= 1'b0;
      end else if (clk_en_i) begin
         wake_o <= wait_mode_i && !stop_mode_i && ctrl_q[BIT_ZERO_FLAG]
                   && ctrl_q[BIT_IRQ_EN];
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         if (rd_i) begin
            unique case (addr_i)
               ADDR_STATUS_CONTROL: rdata_o <= ctrl_q;
               ADDR_COUNTER:        rdata_o <= cnt_q;
               ADDR_PRESCALER:      rdata_o <= {1'b0, pre_q};
               ADDR_IRQ_MASK:       rdata_o <= mask_q;
            endcase
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

   // ----------------------------------------
   // Checks: divider and prescaler
   // ----------------------------------------
   // Eleven quiet cycles after a strobe rule out a period below twelve
   AST_DIV_TWELVE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      div_tick |=> !div_tick [*8] ##1 !div_tick ##1 !div_tick ##1 !div_tick)
      else $error("Prescaler strobe faster than divide by twelve");

   AST_DIV_HOLD: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (adv && !run) |=> div_q == 4'h0)
      else $error("Divider not restarted while stopped");

   AST_PRE_STEP: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (adv && run && !wr_pre && pre_tick && pre_q != 7'h00)
         |=> pre_q == $past(pre_q) - 7'h01)
      else $error("Prescaler did not step down");

   AST_PRE_IDLE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (adv && run && !wr_pre && !pre_tick) |=> $stable(pre_q))
      else $error("Prescaler moved without strobe");

   AST_PRE_RELOAD: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (adv && run && !wr_pre && pre_tick && pre_q == 7'h00)
         |=> pre_q == PRESCALER_RELOAD)
      else $error("Prescaler did not reload at zero");

   AST_PRE_WRITE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (run && wr_pre) |=> pre_q == $past(wdata_i[6:0]))
      else $error("Prescaler write lost");

   AST_TAP_TICK: assert property (
      @(posedge clk_i) disable iff (reset_i)
      cnt_tick |-> pre_tick)
      else $error("Counter tick without prescaler step");

   AST_TAP_DIRECT: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (tap == 3'h0 && pre_tick) |-> cnt_tick)
      else $error("Tap zero missed a prescaler step");

   // ----------------------------------------
   // Checks: counter
   // ----------------------------------------
   // Stopped timer must neither count nor strobe
   AST_STOPPED_NO_TICK: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !run |-> !div_tick && !cnt_tick)
      else $error("Tick while run bit clear");

   AST_FROZEN: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (adv && !run && !wr_cnt) |=> $stable(cnt_q) && pre_q == PRESCALER_RELOAD)
      else $error("Timer moved while stopped");

   AST_CNT_STEP: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (adv && run && !wr_cnt && cnt_tick && cnt_q != 8'h00)
         |=> cnt_q == $past(cnt_q) - 8'h01)
      else $error("Counter did not step down");

   AST_CNT_IDLE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (adv && !wr_cnt && !cnt_tick) |=> $stable(cnt_q))
      else $error("Counter moved without tick");

   AST_CNT_RELOAD: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (adv && run && !wr_cnt && cnt_tick && cnt_q == 8'h00)
         |=> cnt_q == COUNTER_RELOAD)
      else $error("Counter did not reload at zero");

   AST_CNT_WRITE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_cnt |=> cnt_q == $past(wdata_i))
      else $error("Counter write lost");

   AST_WR_BEATS_ZERO: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (wr_cnt && run && cnt_tick && cnt_q == 8'h01 && wdata_i != ZERO_BYTE)
         |=> ctrl_q[BIT_ZERO_FLAG] == $past(ctrl_q[BIT_ZERO_FLAG]))
      else $error("Flag set although a write met the zero step");

   // ----------------------------------------
   // Checks: zero flag and interrupt
   // ----------------------------------------
   AST_ZERO_SET: assert property (
      @(posedge clk_i) disable iff (reset_i)
      zero_evt |=> cnt_q == 8'h00 && ctrl_q[BIT_ZERO_FLAG])
      else $error("Zero reached without flag");

   AST_WR_ZERO: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (wr_cnt && wdata_i == ZERO_BYTE) |=> ctrl_q[BIT_ZERO_FLAG])
      else $error("Writing zero did not set flag");

   AST_CTRL_ZERO: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (wr_ctrl && wdata_i[BIT_ZERO_FLAG]) |=> ctrl_q[BIT_ZERO_FLAG])
      else $error("Status bit seven write did not set flag");

   // Only software may drop the flag, else the request would vanish
   AST_FLAG_STICKY: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (ctrl_q[BIT_ZERO_FLAG] && !wr_ctrl) |=> ctrl_q[BIT_ZERO_FLAG])
      else $error("Zero flag cleared by hardware");

   AST_CTRL_WRITE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_ctrl |=> ctrl_q[6:0] == $past(wdata_i[6:0]))
      else $error("Status write lost");

   AST_MASK_WRITE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_mask |=> mask_q == $past(wdata_i))
      else $error("Mask write lost");

   AST_IRQ: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && ctrl_q[BIT_ZERO_FLAG] && ctrl_q[BIT_IRQ_EN]
         && mask_q[BIT_ZERO_FLAG]) |=> irq_o)
      else $error("Interrupt not raised");

   AST_IRQ_LOW: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && !(ctrl_q[BIT_ZERO_FLAG] && ctrl_q[BIT_IRQ_EN]
         && mask_q[BIT_ZERO_FLAG])) |=> !irq_o)
      else $error("Interrupt raised without cause");

   AST_WAKE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && wait_mode_i && !stop_mode_i && ctrl_q[BIT_ZERO_FLAG]
         && ctrl_q[BIT_IRQ_EN]) |=> wake_o)
      else $error("No wake-up from wait mode");

   AST_WAKE_STOP: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && stop_mode_i) |=> !wake_o)
      else $error("Wake-up raised in stop mode");

   AST_STOP_HOLD: assert property (
      @(posedge clk_i) disable iff (reset_i)
      stop_mode_i |=> $stable(cnt_q) && $stable(pre_q) && $stable(ctrl_q)
         && $stable(mask_q) && $stable(div_q))
      else $error("State changed in stop mode");

   // ----------------------------------------
   // Checks: read port and clock enable
   // ----------------------------------------
   // A low enable must freeze outputs too, not only the counters
   AST_CLK_EN_HOLD: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !clk_en_i |=> $stable(cnt_q) && $stable(pre_q) && $stable(ctrl_q)
         && $stable(mask_q) && $stable(div_q) && $stable(rdata_o)
         && $stable(irq_o) && $stable(wake_o))
      else $error("State changed with clock enable low");

   AST_RDATA_IDLE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && !rd_i) |=> rdata_o == 8'h00)
      else $error("Read data outside a read");

   AST_READ_CNT: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && rd_i && addr_i == ADDR_COUNTER) |=> rdata_o == $past(cnt_q))
      else $error("Counter read wrong");

   AST_READ_PRE: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && rd_i && addr_i == ADDR_PRESCALER)
         |=> rdata_o == {1'b0, $past(pre_q)})
      else $error("Prescaler read wrong");

   AST_READ_CTRL: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && rd_i && addr_i == ADDR_STATUS_CONTROL)
         |=> rdata_o == $past(ctrl_q))
      else $error("Status read wrong");

   AST_READ_MASK: assert property (
      @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && rd_i && addr_i == ADDR_IRQ_MASK)
         |=> rdata_o == $past(mask_q))
      else $error("Mask read wrong");
endmodule
`default_nettype wire

// File: sim/pdt_tb.sv
// Self-checking testbench for the prescaled down timer
`default_nettype none
module tb
   import pdt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i       = 1'b0;
   logic       reset_i     = 1'b1;
   logic       clk_en_i    = 1'b1;
   logic       stop_mode_i = 1'b0;
   logic       wait_mode_i = 1'b0;
   logic [1:0] addr_i      = 2'h0;
   logic [7:0] wdata_i     = 8'h00;
   logic       wr_i        = 1'b0;
   logic       rd_i        = 1'b0;
   logic [7:0] rdata_o;
   logic       irq_o;
   logic       wake_o;
   logic [7:0] v;
   logic [7:0] w;
   int         n;
   int         failures    = 0;
   int         cmp_count   = 0;

   always #5 clk_i = ~clk_i;

   pdt_timer pdt_timer_inst (.clk_i(clk_i), .reset_i(reset_i),
      .clk_en_i(clk_en_i), .stop_mode_i(stop_mode_i),
      .wait_mode_i(wait_mode_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
      .wake_o(wake_o));

   // ----------------------------------------
   // Checking and verdict
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (failures == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      // Data stand in the cycle after the strobe; taken at its closing edge
      @(posedge clk_i);
      d = rdata_o;
   endtask

   // Bounded so a dead interrupt ends the run instead of hanging it
   task automatic wait_irq(output int cyc);
      cyc = 0;
      while (irq_o !== 1'b1) begin
         @(posedge clk_i);
         cyc++;
         if (cyc > 4000) begin
            failures++;
            give_verdict();
         end
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(ADDR_COUNTER, v);
      chk(v, COUNTER_RELOAD);
      rd(ADDR_PRESCALER, v);
      chk(v, {1'b0, PRESCALER_RELOAD});
      rd(ADDR_STATUS_CONTROL, v);
      chk(v, CTRL_RESET);
      // Run bit clear: prescaler write refused, nothing moves
      wr(ADDR_PRESCALER, 8'h10);
      repeat (40) @(posedge clk_i);
      rd(ADDR_PRESCALER, v);
      chk(v, 8'h7F);
      rd(ADDR_COUNTER, v);
      chk(v, COUNTER_RELOAD);
      wr(ADDR_IRQ_MASK, 8'h80);
      wr(ADDR_STATUS_CONTROL, 8'h48);
      // Prescaler phase unknown, so two neighbours are legal
      wr(ADDR_PRESCALER, 8'h01);
      repeat (23) @(posedge clk_i);
      rd(ADDR_PRESCALER, v);
      chk(8'(v == 8'h7F || v == 8'h7E), 8'h01);
      // Two ticks from 02 to zero, one tick period is 12 << tap
      for (int t = 0; t < 8; t++) begin
         wr(ADDR_STATUS_CONTROL, 8'h48 | 8'(t));
         wr(ADDR_COUNTER, 8'h02);
         wait_irq(n);
         chk(8'(n > 12 * (1 << t) && n <= 24 * (1 << t) + 4), 8'h01);
      end
      repeat (20) @(posedge clk_i);
      chk({7'h0, irq_o}, 8'h01);
      rd(ADDR_STATUS_CONTROL, v);
      chk(v, 8'hCF);
      wr(ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clk_i);
      chk({7'h0, irq_o}, 8'h00);
      wr(ADDR_IRQ_MASK, 8'h80);
      wr(ADDR_STATUS_CONTROL, 8'hC8);
      repeat (2) @(posedge clk_i);
      chk({7'h0, irq_o}, 8'h01);
      wait_mode_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({7'h0, wake_o}, 8'h01);
      stop_mode_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({7'h0, wake_o}, 8'h00);
      rd(ADDR_COUNTER, w);
      repeat (30) @(posedge clk_i);
      wr(ADDR_COUNTER, 8'h55);
      rd(ADDR_COUNTER, v);
      chk(v, w);
      stop_mode_i <= 1'b0;
      wait_mode_i <= 1'b0;
      // Enable low for forty cycles: at most one step may slip through
      wr(ADDR_PRESCALER, 8'h40);
      rd(ADDR_PRESCALER, w);
      clk_en_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      clk_en_i <= 1'b1;
      rd(ADDR_PRESCALER, v);
      chk(8'((w - v) <= 8'h01), 8'h01);
      // Through zero and on to the reload value
      wr(ADDR_COUNTER, 8'h01);
      repeat (23) @(posedge clk_i);
      rd(ADDR_COUNTER, v);
      chk(8'(v == 8'hFF || v == 8'hFE), 8'h01);
      wr(ADDR_STATUS_CONTROL, 8'h48);
      rd(ADDR_STATUS_CONTROL, v);
      chk(v & 8'h80, 8'h00);
      wr(ADDR_COUNTER, ZERO_BYTE);
      rd(ADDR_STATUS_CONTROL, v);
      chk(v & 8'h80, 8'h80);
      wr(ADDR_STATUS_CONTROL, 8'h48);
      wr(ADDR_STATUS_CONTROL, 8'hC8);
      rd(ADDR_STATUS_CONTROL, v);
      chk(v & 8'h80, 8'h80);
      give_verdict();
   end
endmodule
`default_nettype wire
